// file: ssp_port.sv
// Added by the designer: the AXI4-Lite register port and the register addresses.
module ssp_port
  import ssp_pkg::*;
(
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // axi4-lite write address / data / response
  input  wire logic [4:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read
  input  wire logic [4:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // clock sources for master modes
  input  wire logic        sub_clk_in,
  input  wire logic        timer_period_match,
  // spi pins
  input  wire logic        sck_in,
  output logic             sck_out,
  output logic             sck_oe_n,
  input  wire logic        sdi_in,
  output logic             sdo_out,
  output logic             sdo_oe_n,
  input  wire logic        slave_select_n_in,
  output logic             slave_select_n_out,
  output logic             slave_select_n_oe_n,
  // interrupt
  output logic             irq
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [2:0] serial_mode_sel;
  logic [1:0] debounce_sel;
  logic       serial_module_on;
  logic       slave_incomplete_flag;
  logic [1:0] ctrl2_spare;
  logic       clock_idle_polarity;
  logic       clock_edge_sel;
  logic       bit_order_sel;
  logic       select_pin_enable;
  logic       write_collision;
  logic       transfer_done_flag;
  logic [7:0] shift_data_reg;
  logic [1:0] irq_enable;
  logic [1:0] irq_status;
  logic       busy;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [4:0] sync_a;
  logic [4:0] sync_b;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      // select input idles high: no false select edge after reset
      sync_a <= 5'h04;
      sync_b <= 5'h04;
    end else begin
      sync_a <= {timer_period_match, sub_clk_in, slave_select_n_in, sdi_in, sck_in};
      sync_b <= sync_a;
    end
  end
  logic sck_s, sdi_s, sel_s, sub_s, tmr_s;
  assign {tmr_s, sub_s, sel_s, sdi_s, sck_s} = sync_b;

  function automatic logic is_master(input logic [2:0] m);
    is_master = (m <= SSP_M_TMR);
  endfunction : is_master

  logic active;
  logic master_mode;
  logic slave_mode;
  assign active      = serial_module_on && (serial_mode_sel != SSP_OFF);
  assign master_mode = active && is_master(serial_mode_sel);
  assign slave_mode  = active && (serial_mode_sel == SSP_SLAVE);

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  logic [4:0] aw_addr;
  logic       aw_held;
  logic [7:0] w_byte;
  logic       w_lane;
  logic       w_held;
  logic       wr_go;
  assign wr_go = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_held       <= 1'b0;
      aw_addr       <= 5'h00;
      s_axi_awready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !s_axi_awready;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      w_held       <= 1'b0;
      w_byte       <= 8'h00;
      w_lane       <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_wready <= !w_held && !s_axi_wready;
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_byte <= s_axi_wdata[7:0];
        w_lane <= s_axi_wstrb[0];
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  logic wr_ctrl0, wr_ctrl2, wr_data, wr_ien, wr_iclr, wr_hit;
  assign wr_ctrl0 = wr_go && w_lane && aw_addr == {1'b0, ADDR_CTRL0};
  assign wr_ctrl2 = wr_go && w_lane && aw_addr == {1'b0, ADDR_CTRL2};
  assign wr_data  = wr_go && w_lane && aw_addr == {1'b0, ADDR_DATA};
  assign wr_ien   = wr_go && w_lane && aw_addr == {1'b1, ADDR_IRQ_EN};
  assign wr_iclr  = wr_go && w_lane && aw_addr == {1'b1, ADDR_IRQ_CLR};
  assign wr_hit   = (aw_addr[4] == PAGE_SERIAL[0] && aw_addr[3:2] != 2'h3)
                 || (aw_addr[4] == PAGE_IRQ[0] && aw_addr[3] == 1'b0);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? 2'h0 : 2'h2;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic [7:0] ctrl0_view, ctrl2_view;
  assign ctrl0_view = {serial_mode_sel, 1'b0, debounce_sel, serial_module_on,
                       slave_incomplete_flag};
  assign ctrl2_view = {ctrl2_spare, clock_idle_polarity, clock_edge_sel, bit_order_sel,
                       select_pin_enable, write_collision, transfer_done_flag};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= 2'h0;
        case (s_axi_araddr)
          {1'b0, ADDR_CTRL0}:   s_axi_rdata <= {24'h0, ctrl0_view};
          {1'b0, ADDR_CTRL2}:   s_axi_rdata <= {24'h0, ctrl2_view};
          {1'b0, ADDR_DATA}:    s_axi_rdata <= {24'h0, shift_data_reg};
          {1'b1, ADDR_IRQ_EN}:  s_axi_rdata <= {30'h0, irq_enable};
          {1'b1, ADDR_IRQ_CLR}: s_axi_rdata <= 32'h0;
          {1'b0, ADDR_STATUS}:  s_axi_rdata <= {30'h0, irq_status};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // master bit clock
  // ----------------------------------------
  logic [5:0] div_cnt;
  logic       src_q;
  logic       tmr_pq;
  logic       tick;
  logic       src_edge;
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      src_q  <= 1'b0;
      tmr_pq <= 1'b0;
    end else begin
      src_q  <= sub_s;
      tmr_pq <= tmr_s;
    end
  end

  logic [5:0] half_lim;
  always_comb begin
    half_lim = HALF_DIV64;
    src_edge = 1'b0;
    case (serial_mode_sel)
      SSP_M_DIV4:  half_lim = HALF_DIV4;
      SSP_M_DIV16: half_lim = HALF_DIV16;
      SSP_M_DIV64: half_lim = HALF_DIV64;
      SSP_M_SUB:   src_edge = sub_s != src_q;
      SSP_M_TMR:   src_edge = tmr_s && !tmr_pq;
      default:     src_edge = 1'b0;
    endcase
  end
  assign tick = is_master(serial_mode_sel)
              ? (serial_mode_sel <= SSP_M_DIV64 ? div_cnt == half_lim : src_edge)
              : 1'b0;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) div_cnt <= 6'h00;
    else if (tick || !busy) div_cnt <= 6'h00;
    else div_cnt <= div_cnt + 6'h01;
  end

  // ----------------------------------------
  // shifter
  // ----------------------------------------
  logic       phase;
  logic [2:0] bit_cnt;
  logic [7:0] shifter;
  logic       out_bit;
  logic       sck_pq;
  logic       sck_rise, sck_fall, cap_edge, drv_edge;
  logic       sel_pq;
  logic       done_ev, inc_ev;
  logic       sel_ok;
  assign sel_ok   = !select_pin_enable || !sel_s;
  assign sck_rise = sck_s && !sck_pq;
  assign sck_fall = !sck_s && sck_pq;
  assign cap_edge = clock_edge_sel ? sck_fall : sck_rise;
  assign drv_edge = clock_edge_sel ? sck_rise : sck_fall;
  logic [7:0] shifted;
  logic       m_cap;
  assign shifted = bit_order_sel ? {shifter[6:0], sdi_s} : {sdi_s, shifter[7:1]};
  // master captures on the selected edge whatever the idle level
  assign m_cap   = sck_out == clock_edge_sel;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_pq <= 1'b0;
      sel_pq <= 1'b1;
    end else begin
      sck_pq <= sck_s;
      sel_pq <= sel_s;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy    <= 1'b0;
      phase   <= 1'b0;
      bit_cnt <= 3'h0;
      shifter <= DATA_RESET;
      out_bit <= 1'b0;
      sck_out <= 1'b0;
      done_ev <= 1'b0;
      inc_ev  <= 1'b0;
      shift_data_reg <= DATA_RESET;
    end else begin
      done_ev <= 1'b0;
      inc_ev  <= 1'b0;
      if (!active) begin
        busy    <= 1'b0;
        sck_out <= clock_idle_polarity;
      end else if (wr_data && busy) begin
        shift_data_reg <= shift_data_reg; // write collision, data ignored
      end else if (wr_data) begin
        shift_data_reg <= w_byte;
        shifter <= w_byte;
        out_bit <= bit_order_sel ? w_byte[7] : w_byte[0];
        bit_cnt <= 3'h0;
        phase   <= 1'b0;
        busy    <= master_mode;
      end else if (master_mode && busy && tick) begin
        phase   <= !phase;
        sck_out <= !sck_out;
        if (m_cap) shifter <= shifted;
        else out_bit <= bit_order_sel ? shifter[7] : shifter[0];
        if (phase) begin
          bit_cnt <= bit_cnt + 3'h1;
          if (bit_cnt == BITS_PER_XFER) begin
            busy <= 1'b0;
            done_ev <= 1'b1;
            shift_data_reg <= m_cap ? shifted : shifter;
          end
        end
      end else if (master_mode) begin
        if (!busy) sck_out <= clock_idle_polarity;
      end else if (slave_mode && sel_ok) begin
        if (cap_edge) begin
          shifter <= shifted;
          bit_cnt <= bit_cnt + 3'h1;
          busy    <= 1'b1;
          if (bit_cnt == BITS_PER_XFER) begin
            busy <= 1'b0;
            done_ev <= 1'b1;
            shift_data_reg <= shifted;
          end
        end else if (drv_edge) begin
          out_bit <= bit_order_sel ? shifter[7] : shifter[0];
        end
      end else if (slave_mode && select_pin_enable && sel_s && !sel_pq) begin
        if (busy) inc_ev <= 1'b1;
        busy    <= 1'b0;
        bit_cnt <= 3'h0;
      end
    end
  end

  // ----------------------------------------
  // control registers and flags
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      serial_mode_sel     <= MODE_RESET;
      debounce_sel        <= 2'h0;
      serial_module_on    <= 1'b0;
      ctrl2_spare         <= CTRL2_RESET[7:6];
      clock_idle_polarity <= CTRL2_RESET[CTRL2_POL_BIT];
      clock_edge_sel      <= CTRL2_RESET[CTRL2_EDGE_BIT];
      bit_order_sel       <= CTRL2_RESET[CTRL2_ORD_BIT];
      select_pin_enable   <= CTRL2_RESET[CTRL2_SELECT_PIN_ENABLE_BIT];
    end else begin
      if (wr_ctrl0) begin // a ctrl0 write also rewrites mode, debounce and the on bit
        serial_mode_sel  <= w_byte[CTRL0_MODE_LSB +: 3];
        debounce_sel     <= w_byte[CTRL0_DEB_LSB +: 2];
        serial_module_on <= w_byte[CTRL0_ON_BIT];
      end
      if (wr_ctrl2) begin
        ctrl2_spare         <= w_byte[7:6];
        clock_idle_polarity <= w_byte[CTRL2_POL_BIT];
        clock_edge_sel      <= w_byte[CTRL2_EDGE_BIT];
        bit_order_sel       <= w_byte[CTRL2_ORD_BIT];
        select_pin_enable   <= w_byte[CTRL2_SELECT_PIN_ENABLE_BIT];
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      slave_incomplete_flag <= 1'b0;
      transfer_done_flag    <= 1'b0;
      write_collision       <= 1'b0;
    end else begin
      if (inc_ev && slave_mode) slave_incomplete_flag <= 1'b1;
      else if (wr_ctrl0) slave_incomplete_flag <= w_byte[CTRL0_SIF_BIT];
      if (done_ev || (inc_ev && slave_mode)) transfer_done_flag <= 1'b1;
      else if (wr_ctrl2) transfer_done_flag <= w_byte[CTRL2_TRF_BIT];
      if (wr_data && busy && active) write_collision <= 1'b1;
      else if (wr_ctrl2) write_collision <= w_byte[CTRL2_WCOL_BIT];
    end
  end

  // ----------------------------------------
  // interrupt
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_status <= 2'h0;
      irq_enable <= 2'h0;
      irq        <= 1'b0;
    end else begin
      if (wr_ien) irq_enable <= w_byte[1:0];
      irq_status[IRQ_TRF_BIT] <= done_ev || (inc_ev && slave_mode)
        || (irq_status[IRQ_TRF_BIT] && !(wr_iclr && w_byte[IRQ_TRF_BIT]));
      irq_status[IRQ_SIF_BIT] <= (inc_ev && slave_mode)
        || (irq_status[IRQ_SIF_BIT] && !(wr_iclr && w_byte[IRQ_SIF_BIT]));
      irq <= |(irq_status & irq_enable);
    end
  end

  // ----------------------------------------
  // pin drivers
  // ----------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sck_oe_n            <= 1'b1;
      sdo_out             <= 1'b0;
      sdo_oe_n            <= 1'b1;
      slave_select_n_out  <= 1'b1;
      slave_select_n_oe_n <= 1'b1;
    end else begin
      sck_oe_n <= !master_mode;
      sdo_out  <= out_bit;
      // slave releases data line while unselected
      sdo_oe_n <= !(master_mode || (slave_mode && sel_ok));
      slave_select_n_out  <= !busy;
      slave_select_n_oe_n <= !(master_mode && select_pin_enable);
    end
  end

endmodule : ssp_port

// file: ssp_pkg.sv
package ssp_pkg;

  // ----------------------------------------
  // register byte addresses
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL0   = 4'h0;
  localparam logic [3:0] ADDR_CTRL2   = 4'h4;
  localparam logic [3:0] ADDR_DATA    = 4'h8;
  localparam logic [3:0] ADDR_STATUS  = 4'hc;
  localparam logic [3:0] ADDR_IRQ_EN  = 4'h0;
  localparam logic [3:0] ADDR_IRQ_CLR = 4'h4;
  localparam logic [1:0] PAGE_SERIAL  = 2'h0;
  localparam logic [1:0] PAGE_IRQ     = 2'h1;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CTRL0_MODE_LSB = 5;
  localparam int CTRL0_DEB_LSB  = 2;
  localparam int CTRL0_ON_BIT   = 1;
  localparam int CTRL0_SIF_BIT  = 0;
  localparam int CTRL2_POL_BIT  = 5;
  localparam int CTRL2_EDGE_BIT = 4;
  localparam int CTRL2_ORD_BIT  = 3;
  localparam int CTRL2_SELECT_PIN_ENABLE_BIT = 2;
  localparam int CTRL2_WCOL_BIT = 1;
  localparam int CTRL2_TRF_BIT  = 0;
  localparam int IRQ_TRF_BIT    = 0;
  localparam int IRQ_SIF_BIT    = 1;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [2:0] MODE_RESET  = 3'h7;
  localparam logic [7:0] CTRL2_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET  = 8'h00;

  // ----------------------------------------
  // timing: system clock divisors (half period minus one, in core clocks)
  // ----------------------------------------
  localparam logic [5:0] HALF_DIV4  = 6'h01;
  localparam logic [5:0] HALF_DIV16 = 6'h07;
  localparam logic [5:0] HALF_DIV64 = 6'h1f;
  localparam logic [2:0] BITS_PER_XFER = 3'h7;

  typedef enum logic [2:0] {
    SSP_M_DIV4  = 3'b000,
    SSP_M_DIV16 = 3'b001,
    SSP_M_DIV64 = 3'b010,
    SSP_M_SUB   = 3'b011,
    SSP_M_TMR   = 3'b100,
    SSP_SLAVE   = 3'b101,
    SSP_I2C     = 3'b110,
    SSP_OFF     = 3'b111
  } ssp_mode_e;

  typedef struct packed {
    logic sck;
    logic sdo;
    logic sel_n;
  } ssp_pins_s;

endpackage : ssp_pkg

// file: ssp_port_chk.sv
module ssp_port_chk
  import ssp_pkg::*;
(
  // clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // register bus
  input wire logic [4:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [4:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  // pins and interrupt
  input wire logic        sck_out,
  input wire logic        sck_oe_n,
  input wire logic        sdo_oe_n,
  input wire logic        slave_select_n_in,
  input wire logic        slave_select_n_oe_n,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // shadow of the control registers
  // ----
  logic [4:0] aw_q;
  logic [7:0] w_q, c0, c2;
  logic       busy, ok;
  logic [1:0] age;
  logic [2:0] md;
  // shadow lags the design, so judge only after writes settle
  assign ok = !busy && (age == 2'h3);
  assign md = c0[7:5];

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      aw_q <= 5'h00;
      w_q  <= 8'h00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready) w_q <= s_axi_wdata[7:0];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      age  <= 2'h3;
    end else if (s_axi_bvalid && s_axi_bready) begin
      busy <= 1'b0;
      age  <= 2'h0;
    end else begin
      if (s_axi_awvalid || s_axi_wvalid) busy <= 1'b1;
      if (age != 2'h3) age <= age + 2'h1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      c0 <= {MODE_RESET, 5'h00};
      c2 <= CTRL2_RESET;
    end else if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0) begin
      if (aw_q == 5'h00) c0 <= w_q;
      if (aw_q == 5'h04) c2 <= w_q;
    end
  end

  // ----
  // properties
  // ----
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!reset_n);

  chk_off_release: assert property (
    ok && (!c0[1] || md >= 3'h6) |-> sck_oe_n && sdo_oe_n && slave_select_n_oe_n)
    else $error("pins driven while module is off");
  chk_sel_float: assert property (
    ok && !c2[2] |-> slave_select_n_oe_n)
    else $error("select pin driven with select disabled");
  chk_slave_clk: assert property (
    ok && md == 3'h5 |-> sck_oe_n)
    else $error("slave drives the serial clock");
  chk_slave_quiet: assert property (
    (ok && md == 3'h5 && c2[2] && slave_select_n_in) [*6] |-> sdo_oe_n)
    else $error("unselected slave drives data out");
  chk_div4_rate: assert property (
    ok && md == 3'h0 && c0[1] && $changed(sck_out) |=> $stable(sck_out))
    else $error("divide-by-4 half bit too short");
  chk_div16_rate: assert property (
    ok && md == 3'h1 && c0[1] && $changed(sck_out) |=> $stable(sck_out) [*7])
    else $error("divide-by-16 half bit too short");
  chk_rd_latency: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rd_unmapped: assert property (
    s_axi_arvalid && s_axi_arready && s_axi_araddr >= 5'h18 |=> s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  chk_irq_fall: assert property (
    $fell(irq) |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
    else $error("interrupt dropped without a write");
endmodule : ssp_port_chk

// file: ssp_peer.sv
module ssp_peer
  import ssp_pkg::*;
(
  // design side pins
  input wire logic sck_m,
  input wire logic p_din,
  // shift options
  input wire logic edge_sel,
  input wire logic msb_first,
  // pins toward the design
  output logic     p_dout,
  output logic     sck_s,
  output logic     sel_n_s
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx, rx;
  int         n;
  logic       act;

  function automatic int pos(input int k);
    return msb_first ? 7 - k : k;
  endfunction : pos

  initial begin
    {act, sck_s, tx, rx} = '0;
    n = 0;
    p_dout = 1'b1;
    sel_n_s = 1'b1;
  end

  // ----
  // slave role: next bit follows each capture edge
  // ----
  always @(sck_m) begin
    if (act && (sck_m ^ edge_sel)) begin
      rx[pos(n)] = p_din;
      n++;
      if (n == 8) begin
        act = 1'b0;
        p_dout = ~p_dout;
      end else begin
        p_dout = tx[pos(n)];
      end
    end
  end

  task automatic arm(input logic [7:0] b);
    tx = b;
    n = 0;
    act = 1'b1;
    p_dout = b[pos(0)];
  endtask : arm

  // ----
  // master role: drives clock and select, idle level is the launch side
  // ----
  task automatic xfer(input logic [7:0] b, input int nb);
    #5;
    sck_s = edge_sel;
    sel_n_s = 1'b0;
    for (int k = 0; k < nb; k++) begin
      p_dout = b[pos(k)];
      #160;
      sck_s = ~sck_s;
      rx[pos(k)] = p_din;
      #160;
      sck_s = ~sck_s;
    end
    #160;
    sel_n_s = 1'b1;
    p_dout = ~p_dout;
  endtask : xfer
endmodule : ssp_peer

// file: ssp_port_tb.sv
module ssp_port_tb
  import ssp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk, reset_n, sub_clk_in, timer_period_match, irq;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, sck_out, sck_oe_n, sdo_out, sdo_oe_n;
  logic        slave_select_n_out, slave_select_n_oe_n, p_dout, sck_s, sel_n_s;
  logic        e_sel, o_msb;
  logic [2:0]  mm, tcnt;
  logic [7:0]  c, d, b;
  logic [33:0] expq[$];
  int          errors, comparisons;
  int          seed = 32'hf88b0dce;

  ssp_port dut (.core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .sub_clk_in,
    .timer_period_match, .sck_in(sck_s), .sck_out, .sck_oe_n, .sdi_in(p_dout), .sdo_out,
    .sdo_oe_n, .slave_select_n_in(sel_n_s), .slave_select_n_out, .slave_select_n_oe_n,
    .irq);
  ssp_peer peer (.sck_m(sck_out), .p_din(sdo_out), .edge_sel(e_sel), .msb_first(o_msb),
    .p_dout, .sck_s, .sel_n_s);

  always #10 core_clk = ~core_clk;

  // sub clock toggles every 4 cycles, timer match every 8
  always @(posedge core_clk) begin
    tcnt <= tcnt + 3'h1;
    sub_clk_in <= tcnt[2];
    timer_period_match <= (tcnt == 3'h0);
  end

  // ----
  // checking and closing
  // ----
  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_of_test;
    if (errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test

  task automatic tick(inout int n);
    @(posedge core_clk);
    n++;
    if (n > 20000) begin
      errors++;
      end_of_test();
    end
  endtask : tick

  always @(posedge core_clk) begin
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
      check({s_axi_rresp, s_axi_rdata}, expq.pop_front());
    end
  end

  // ----
  // bus master
  // ----
  task automatic wr(input logic [4:0] a, input logic [7:0] v, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // wait one edge first: the last answer still shows in this step
    do begin
      tick(n);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    check({32'h0, s_axi_bresp}, {32'h0, er});
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [7:0] v, input logic [1:0] er);
    int n;
    n = 0;
    expq.push_back({er, 24'h0, v});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      tick(n);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
  endtask : rd

  task automatic wait_irq;
    int n;
    n = 0;
    @(posedge core_clk);
    while (irq !== 1'b1) tick(n);
  endtask : wait_irq

  // ----
  // main sequence
  // ----
  initial begin
    {core_clk, reset_n, tcnt, sub_clk_in, timer_period_match, e_sel, o_msb} = '0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    // responses are always accepted at once
    s_axi_bready <= 1'b1;
    s_axi_rready <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd(5'h00, 8'he0, 2'h0);
    rd(5'h04, 8'h00, 2'h0);
    rd(5'h0c, 8'h00, 2'h0);
    rd(5'h18, 8'h00, 2'h2);
    wr(5'h1c, 8'h55, 2'h2);
    wr(5'h10, 8'h03, 2'h0);
    rd(5'h10, 8'h03, 2'h0);
    for (int m = 0; m < 5; m++) begin
      mm = m[2:0];
      c = {3'h0, mm[1], mm[0], 3'h4};
      e_sel <= mm[1];
      o_msb <= mm[0];
      wr(5'h04, c, 2'h0);
      wr(5'h00, {mm, 5'h02}, 2'h0);
      rd(5'h04, c, 2'h0);
      d = 8'($random(seed));
      b = 8'($random(seed));
      peer.arm(b);
      wr(5'h08, d, 2'h0);
      @(posedge core_clk);
      check({32'h0, slave_select_n_oe_n, slave_select_n_out}, 34'h0);
      if (mm == 3'h2) begin
        wr(5'h08, ~d, 2'h0);
        rd(5'h04, c | 8'h02, 2'h0);
        wr(5'h04, c, 2'h0);
      end
      wait_irq();
      rd(5'h0c, 8'h01, 2'h0);
      rd(5'h08, b, 2'h0);
      check({26'h0, peer.rx}, {26'h0, d});
      wr(5'h14, 8'h03, 2'h0);
      rd(5'h0c, 8'h00, 2'h0);
      check({33'h0, irq}, 34'h0);
    end
    wr(5'h00, 8'he0, 2'h0);
    wr(5'h00, 8'hc2, 2'h0);
    for (int e = 0; e < 2; e++) begin
      mm = e[2:0];
      c = {3'h0, mm[0], mm[0], 3'h4};
      e_sel <= mm[0];
      o_msb <= mm[0];
      wr(5'h04, c, 2'h0);
      wr(5'h00, 8'ha2, 2'h0);
      d = 8'($random(seed));
      b = 8'($random(seed));
      wr(5'h08, d, 2'h0);
      peer.xfer(b, 8);
      wait_irq();
      check({26'h0, peer.rx}, {26'h0, d});
      rd(5'h08, b, 2'h0);
      rd(5'h0c, 8'h01, 2'h0);
      wr(5'h14, 8'h03, 2'h0);
      peer.xfer(b, 5);
      wait_irq();
      rd(5'h0c, 8'h03, 2'h0);
      wr(5'h14, 8'h03, 2'h0);
    end
    wr(5'h00, 8'ha3, 2'h0);
    rd(5'h00, 8'ha3, 2'h0);
    rd(5'h0c, 8'h00, 2'h0);
    wr(5'h10, 8'h01, 2'h0);
    rd(5'h10, 8'h01, 2'h0);
    check({33'h0, irq}, 34'h0);
    wr(5'h10, 8'h03, 2'h0);
    rd(5'h10, 8'h03, 2'h0);
    check({33'h0, irq}, 34'h0);
    wr(5'h14, 8'h03, 2'h0);
    wr(5'h00, 8'he0, 2'h0);
    end_of_test();
  end
endmodule : ssp_port_tb

bind ssp_port ssp_port_chk chk (.core_clk, .reset_n, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rresp,
  .s_axi_rvalid, .sck_out, .sck_oe_n, .sdo_oe_n, .slave_select_n_in,
  .slave_select_n_oe_n, .irq);
